//--- ulsf_consts.svh
// Offsets, field positions, reset values and widths of the line status block
`ifndef ULSF_CONSTS_SVH
`define ULSF_CONSTS_SVH

`define ULSF_ADDR_W          4
`define ULSF_DATA_W          8
`define ULSF_OFF_FIFO_CTRL   4'h2
`define ULSF_OFF_LINE_STATUS 4'h5
`define ULSF_BIT_FIFO_EN     0
`define ULSF_BIT_HOLD_EMPTY  5
`define ULSF_BIT_TX_IDLE     6
`define ULSF_BIT_RXQ_ERR     7
`define ULSF_RST_FIFO_EN     1'b0
`define ULSF_RST_RXQ_ERR     1'b0
`define ULSF_RST_TX_IDLE     1'b1
`define ULSF_RST_HOLD_EMPTY  1'b1
`define ULSF_DATA_ZERO       8'h00
`define ULSF_ERRCNT_W        5
`define ULSF_ERRCNT_ZERO     5'h00
`define ULSF_ERRCNT_ONE      5'h01

`endif

//--- ulsf_pkg.sv
// Types shared by the line status block
`include "ulsf_consts.svh"

package ulsf_pkg;
    typedef logic [`ULSF_ADDR_W-1:0]   ulsf_addr_t;
    typedef logic [`ULSF_DATA_W-1:0]   ulsf_data_t;
    typedef logic [`ULSF_ERRCNT_W-1:0] ulsf_errcnt_t;
endpackage

//--- ulsf_rxerr_if.sv
// Link between the status logic and the receive error tracker
interface ulsf_rxerr_if;
    logic push_err;
    logic pop_err;
    logic clear;
    logic no_err_left;

    modport tracker (
        input  push_err,
        input  pop_err,
        input  clear,
        output no_err_left
    );
    modport user (
        output push_err,
        output pop_err,
        output clear,
        input  no_err_left
    );
endinterface

//--- ulsf_rxerr_tracker.sv
// Counts receive queue entries that carry an error mark
`include "ulsf_consts.svh"

module ulsf_rxerr_tracker (
    input  wire logic    clk_i,
    input  wire logic    rst_i,
    ulsf_rxerr_if.tracker rx_if
);
    ulsf_pkg::ulsf_errcnt_t cnt_r;
    ulsf_pkg::ulsf_errcnt_t cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (rx_if.clear) begin
            cnt_nxt = `ULSF_ERRCNT_ZERO;
        end else begin
            if (rx_if.push_err) begin
                cnt_nxt = cnt_nxt + `ULSF_ERRCNT_ONE;
            end
            if (rx_if.pop_err && (cnt_nxt != `ULSF_ERRCNT_ZERO)) begin
                cnt_nxt = cnt_nxt - `ULSF_ERRCNT_ONE;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= `ULSF_ERRCNT_ZERO;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Looks ahead so a clear event in this cycle sees the updated count
    assign rx_if.no_err_left = (cnt_nxt == `ULSF_ERRCNT_ZERO);
endmodule

//--- ulsf_line_status.sv
// Line status flags of the serial port with their register port
// Functional notes
// - Line status register is read-only; writes change no flag.
// - FIFO mode: error flag sets when a queued entry has parity/framing/break.
// - Error flag only meaningful in FIFO mode; resets to 0.
// - Error flag clears on buffer or status read once no errored data remains.
// - No FIFO: idle flag 1 only while holding and shift stages empty; reset 1.
// - FIFO mode: idle flag sets only when transmit FIFO and shifter empty.
// - Idle flag clears at once when software writes transmit data.
// - FIFO mode: holding-empty flag clears on a write; resets to 1.
// - FIFO mode: holding-empty flag sets when transmit FIFO drains empty.
// - No FIFO: holding-empty clears on write, sets when byte moves to shifter.
`include "ulsf_consts.svh"

module ulsf_line_status (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire ulsf_pkg::ulsf_addr_t addr_i,
    input  wire ulsf_pkg::ulsf_data_t wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output ulsf_pkg::ulsf_data_t      rdata_o,
    output logic                      fifo_en_o,
    input  wire logic                 rx_push_err_i,
    input  wire logic                 rx_pop_err_i,
    input  wire logic                 rx_fifo_clear_i,
    input  wire logic                 rx_buf_read_i,
    input  wire logic                 thr_write_i,
    input  wire logic                 thr_xfer_i,
    input  wire logic                 tx_fifo_empty_i,
    input  wire logic                 shift_busy_i
);
    function automatic logic sel_reg(input ulsf_pkg::ulsf_addr_t a,
                                     input ulsf_pkg::ulsf_addr_t off);
        sel_reg = (a == off);
    endfunction

    logic                 fifo_en_r;
    logic                 fifo_en_nxt;
    logic                 rxq_err_r;
    logic                 rxq_err_nxt;
    logic                 tx_idle_r;
    logic                 tx_idle_nxt;
    logic                 hold_empty_r;
    logic                 hold_empty_nxt;
    ulsf_pkg::ulsf_data_t rdata_r;
    ulsf_pkg::ulsf_data_t rdata_nxt;
    logic                 wr_ctrl;
    logic                 wr_lsr;
    logic                 rd_ctrl;
    logic                 rd_lsr;
    logic                 rxq_set;
    logic                 rxq_clr;

    ulsf_rxerr_if rx_if ();

    assign wr_ctrl = wr_i && sel_reg(addr_i, `ULSF_OFF_FIFO_CTRL);
    assign wr_lsr  = wr_i && sel_reg(addr_i, `ULSF_OFF_LINE_STATUS);
    assign rd_ctrl = rd_i && sel_reg(addr_i, `ULSF_OFF_FIFO_CTRL);
    assign rd_lsr  = rd_i && sel_reg(addr_i, `ULSF_OFF_LINE_STATUS);

    assign rx_if.push_err = fifo_en_r && rx_push_err_i;
    assign rx_if.pop_err  = rx_pop_err_i;
    assign rx_if.clear    = rx_fifo_clear_i;

    ulsf_rxerr_tracker u_tracker (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .rx_if (rx_if.tracker)
    );

    // Control register: only the FIFO enable bit is held
    always_comb begin
        fifo_en_nxt = fifo_en_r;
        if (wr_ctrl) begin
            fifo_en_nxt = wdata_i[`ULSF_BIT_FIFO_EN];
        end
    end

    // Receive queue error summary; a new error beats a clearing read
    assign rxq_set = fifo_en_r && rx_push_err_i;
    assign rxq_clr = (rx_buf_read_i || rd_lsr) && rx_if.no_err_left;

    always_comb begin
        rxq_err_nxt = rxq_err_r;
        if (rxq_set) begin
            rxq_err_nxt = 1'b1;
        end else if (rxq_clr) begin
            rxq_err_nxt = 1'b0;
        end
    end

    // Holding-empty flag; a write in the same cycle wins over a set
    always_comb begin
        hold_empty_nxt = hold_empty_r;
        if (thr_write_i) begin
            hold_empty_nxt = 1'b0;
        end else if (fifo_en_r) begin
            if (tx_fifo_empty_i) begin
                hold_empty_nxt = 1'b1;
            end
        end else if (thr_xfer_i) begin
            hold_empty_nxt = 1'b1;
        end
    end

    // Idle only while holding stage or FIFO and the shifter are both empty
    always_comb begin
        tx_idle_nxt = 1'b0;
        if (!thr_write_i) begin
            if (fifo_en_r) begin
                tx_idle_nxt = tx_fifo_empty_i && !shift_busy_i;
            end else begin
                tx_idle_nxt = hold_empty_nxt && !shift_busy_i;
            end
        end
    end

    // Read data; status bits outside this block read as zero
    always_comb begin
        rdata_nxt = `ULSF_DATA_ZERO;
        if (rd_lsr) begin
            rdata_nxt[`ULSF_BIT_RXQ_ERR]    = rxq_err_r && fifo_en_r;
            rdata_nxt[`ULSF_BIT_TX_IDLE]    = tx_idle_r;
            rdata_nxt[`ULSF_BIT_HOLD_EMPTY] = hold_empty_r;
        end else if (rd_ctrl) begin
            rdata_nxt[`ULSF_BIT_FIFO_EN]    = fifo_en_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fifo_en_r    <= `ULSF_RST_FIFO_EN;
            rxq_err_r    <= `ULSF_RST_RXQ_ERR;
            tx_idle_r    <= `ULSF_RST_TX_IDLE;
            hold_empty_r <= `ULSF_RST_HOLD_EMPTY;
            rdata_r      <= `ULSF_DATA_ZERO;
        end else begin
            fifo_en_r    <= fifo_en_nxt;
            rxq_err_r    <= rxq_err_nxt;
            tx_idle_r    <= tx_idle_nxt;
            hold_empty_r <= hold_empty_nxt;
            rdata_r      <= rdata_nxt;
        end
    end

    assign rdata_o   = rdata_r;
    assign fifo_en_o = fifo_en_r;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_RO_WRITE: assert property (
        wr_lsr |=> (fifo_en_r == $past(fifo_en_r)))
        else $error("status write altered control state");

    AST_ERR_SET: assert property (
        fifo_en_r && rx_push_err_i |=> rxq_err_r)
        else $error("error flag not set by errored entry");

    AST_ERR_NOFIFO: assert property (
        rd_lsr && !fifo_en_r |=> !rdata_o[`ULSF_BIT_RXQ_ERR])
        else $error("error flag visible outside FIFO mode");

    AST_ERR_CLR: assert property (
        rxq_clr && !rxq_set |=> !rxq_err_r)
        else $error("error flag not cleared by read");

    AST_IDLE_NOFIFO: assert property (
        !fifo_en_r && !thr_write_i && !thr_xfer_i
        && (shift_busy_i || !hold_empty_r) |=> !tx_idle_r)
        else $error("idle flag set with data in holding or shift stage");

    AST_IDLE_FIFO: assert property (
        fifo_en_r && !thr_write_i
        |=> tx_idle_r == ($past(tx_fifo_empty_i) && !$past(shift_busy_i)))
        else $error("idle flag wrong in FIFO mode");

    AST_IDLE_CLR: assert property (
        thr_write_i |=> !tx_idle_r)
        else $error("idle flag not cleared by transmit write");

    AST_HOLD_CLR: assert property (
        thr_write_i |=> !hold_empty_r && !tx_idle_r)
        else $error("holding-empty flag not cleared by write");

    AST_HOLD_SET: assert property (
        fifo_en_r && tx_fifo_empty_i && !thr_write_i |=> hold_empty_r)
        else $error("holding-empty flag not set on drained FIFO");

    AST_HOLD_XFER: assert property (
        !fifo_en_r && thr_xfer_i && !thr_write_i |=> hold_empty_r)
        else $error("holding-empty flag not set after move to shifter");

    AST_READ_LATE: assert property (
        rd_lsr |=> rdata_o[`ULSF_BIT_TX_IDLE] == $past(tx_idle_r)
               && rdata_o[`ULSF_BIT_HOLD_EMPTY] == $past(hold_empty_r))
        else $error("status read does not show prior-edge flags");

    AST_ERR_NOSET: assert property (
        !fifo_en_r && !rxq_err_r |=> !rxq_err_r)
        else $error("error flag set outside FIFO mode");

    AST_ERR_KEEP: assert property (
        rxq_err_r && !rxq_clr |=> rxq_err_r)
        else $error("error flag dropped without a clearing read");

    AST_ERR_VIS: assert property (
        rd_lsr && fifo_en_r
        |=> rdata_o[`ULSF_BIT_RXQ_ERR] == $past(rxq_err_r))
        else $error("error flag missing from status read");

    AST_HOLD_KEEP_FIFO: assert property (
        fifo_en_r && !hold_empty_r && !tx_fifo_empty_i |=> !hold_empty_r)
        else $error("holding-empty flag set with data in transmit FIFO");

    AST_HOLD_KEEP_NOFIFO: assert property (
        !fifo_en_r && !hold_empty_r && !thr_xfer_i |=> !hold_empty_r)
        else $error("holding-empty flag set before move to shifter");

    AST_RD_QUIET: assert property (
        !rd_i |=> rdata_o == `ULSF_DATA_ZERO)
        else $error("read data not zero outside a read answer");
endmodule

//--- ulsf_line_status_tb_top.sv
// Self-checking bench of the line status flags
`define ULSF_CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
    n_errors++; $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end

module ulsf_line_status_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk_i           = 1'h0;
    logic                 rst_i           = 1'h1;
    ulsf_pkg::ulsf_addr_t addr_i          = 4'h0;
    ulsf_pkg::ulsf_data_t wdata_i         = 8'h00;
    logic                 wr_i            = 1'h0;
    logic                 rd_i            = 1'h0;
    logic                 rx_push_err_i   = 1'h0;
    logic                 rx_pop_err_i    = 1'h0;
    logic                 rx_fifo_clear_i = 1'h0;
    logic                 rx_buf_read_i   = 1'h0;
    logic                 thr_write_i     = 1'h0;
    logic                 thr_xfer_i      = 1'h0;
    logic                 tx_fifo_empty_i = 1'h1;
    logic                 shift_busy_i    = 1'h0;
    logic                 rd_d            = 1'h0;
    ulsf_pkg::ulsf_data_t rdata_o;
    ulsf_pkg::ulsf_data_t exp_v;
    logic                 fifo_en_o;
    ulsf_pkg::ulsf_data_t exp_q[$];
    int                   n_errors        = 0;
    int                   tests_run       = 0;
    int                   seed            = 86694;

    ulsf_line_status ulsf_line_status_inst (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fifo_en_o(fifo_en_o),
        .rx_push_err_i(rx_push_err_i), .rx_pop_err_i(rx_pop_err_i),
        .rx_fifo_clear_i(rx_fifo_clear_i), .rx_buf_read_i(rx_buf_read_i),
        .thr_write_i(thr_write_i), .thr_xfer_i(thr_xfer_i),
        .tx_fifo_empty_i(tx_fifo_empty_i), .shift_busy_i(shift_busy_i)
    );

    always #2 clk_i = ~clk_i;

    task automatic report_and_stop();
        if (n_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wr(input ulsf_pkg::ulsf_addr_t a,
                      input ulsf_pkg::ulsf_data_t d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'h1;
        @(posedge clk_i);
        wr_i <= 1'h0;
    endtask

    task automatic rd(input ulsf_pkg::ulsf_addr_t a,
                      input ulsf_pkg::ulsf_data_t e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'h1;
        exp_q.push_back(e);
        @(posedge clk_i);
        rd_i <= 1'h0;
    endtask

    // Order: push, pop, clear, buffer read, holding write, transfer
    task automatic ev(input logic [5:0] v);
        @(posedge clk_i);
        {rx_push_err_i, rx_pop_err_i, rx_fifo_clear_i, rx_buf_read_i,
         thr_write_i, thr_xfer_i} <= v;
        @(posedge clk_i);
        {rx_push_err_i, rx_pop_err_i, rx_fifo_clear_i, rx_buf_read_i,
         thr_write_i, thr_xfer_i} <= 6'h00;
        repeat (2) @(posedge clk_i);
    endtask

    task automatic lv(input logic empty, input logic busy);
        @(posedge clk_i);
        tx_fifo_empty_i <= empty;
        shift_busy_i <= busy;
        repeat (2) @(posedge clk_i);
    endtask

    always @(posedge clk_i) rd_d <= rd_i;

    // Read data only in the cycle after a read strobe
    always @(negedge clk_i) begin
        if (rd_d) begin
            exp_v = exp_q.pop_front();
            `ULSF_CHK(rdata_o, exp_v)
        end else if (!rst_i) begin
            `ULSF_CHK(rdata_o, 8'h00)
        end
    end

    initial begin
        ulsf_pkg::ulsf_data_t d;
        ulsf_pkg::ulsf_addr_t a;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        rd(4'h5, 8'h60);
        rd(4'h2, 8'h00);
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            a = 4'($random(seed));
            if (a == 4'h2 || a == 4'h5) a = 4'h0;
            wr(4'h5, d);
            wr(a, d);
            rd(a, 8'h00);
        end
        rd(4'h5, 8'h60);
        ev(6'h02);
        rd(4'h5, 8'h00);
        lv(1'h1, 1'h1);
        ev(6'h01);
        rd(4'h5, 8'h20);
        lv(1'h1, 1'h0);
        rd(4'h5, 8'h60);
        ev(6'h20);
        d = 8'($random(seed));
        d[0] = 1'h1;
        wr(4'h2, d);
        @(negedge clk_i);
        `ULSF_CHK(fifo_en_o, 1'h1)
        rd(4'h5, 8'h60);
        lv(1'h0, 1'h0);
        rd(4'h5, 8'h20);
        ev(6'h02);
        rd(4'h5, 8'h00);
        lv(1'h1, 1'h1);
        rd(4'h5, 8'h20);
        lv(1'h1, 1'h0);
        rd(4'h5, 8'h60);
        ev(6'h20);
        ev(6'h20);
        rd(4'h5, 8'hE0);
        ev(6'h14);
        rd(4'h5, 8'hE0);
        ev(6'h08);
        rd(4'h5, 8'hE0);
        rd(4'h5, 8'h60);
        ev(6'h20);
        rd(4'h5, 8'hE0);
        ev(6'h14);
        rd(4'h5, 8'h60);
        ev(6'h20);
        wr(4'h2, 8'h00);
        rd(4'h5, 8'h60);
        ev(6'h02);
        rd(4'h5, 8'h00);
        // Reset in mid-run with a hidden error and a full holding stage
        @(posedge clk_i);
        rst_i <= 1'h1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        wr(4'h2, 8'h01);
        rd(4'h2, 8'h01);
        rd(4'h5, 8'h60);
        ev(6'h20);
        ev(6'h14);
        rd(4'h5, 8'h60);
        repeat (3) @(posedge clk_i);
        report_and_stop();
    end

    // Run takes about 155 cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        report_and_stop();
    end
endmodule
